// ==== verilog/fcp_pkg.sv ====
// package: constants and carriers for the fifo configuration and port control
package fcp_pkg;

  // ----------------------------------------------------------------
  // reset and timing counts
  // ----------------------------------------------------------------
  localparam int unsigned RST_EDGES    = 4;
  localparam int unsigned READY_DELAY  = 2;

  // ----------------------------------------------------------------
  // preset offsets
  // ----------------------------------------------------------------
  localparam logic [12:0] OFS_64   = 13'h0040;
  localparam logic [12:0] OFS_16   = 13'h0010;
  localparam logic [12:0] OFS_8    = 13'h0008;
  localparam logic [12:0] OFS_256  = 13'h0100;
  localparam logic [12:0] OFS_1024 = 13'h0400;
  localparam logic [12:0] OFS_RST  = 13'h0040;
  localparam int unsigned PARITY_BIT = 8;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FCP_PROG_PRESET = 2'h0,
    FCP_PROG_SERIAL = 2'h1,
    FCP_PROG_PAR    = 2'h2,
    FCP_PROG_IP     = 2'h3
  } fcp_prog_t;

  typedef struct packed {
    logic port_a_select_n;
    logic port_a_direction;
    logic port_a_transfer_qualifier;
    logic port_a_mailbox_select;
  } fcp_port_ctl_t;

endpackage

// ==== verilog/fcp_low_counter.sv ====
// module: counts clock edges a low-active pin has been held low
`timescale 1ns/1ps
module fcp_low_counter #(
  parameter int unsigned NEED = 4
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_n_i,
  output logic      held_o
);
  typedef struct packed {
    logic [2:0] cnt;
    logic       held;
  } fcp_lc_state_t;

  fcp_lc_state_t st_r;
  fcp_lc_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (pin_n_i) begin
      st_nxt.cnt = 3'h0;
      st_nxt.held = 1'b0;
    end else if (st_r.cnt < 3'(NEED)) begin
      st_nxt.cnt = st_r.cnt + 3'h1;
    end
    if (!pin_n_i && st_nxt.cnt >= 3'(NEED)) begin
      st_nxt.held = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign held_o = st_r.held;
endmodule

// ==== verilog/fcp_fifo_ctrl.sv ====
// module: configuration, offset loading and port control of a 36-bit fifo
`timescale 1ns/1ps
module fcp_fifo_ctrl #(
  parameter int unsigned DEPTH_LOG = 11,
  parameter int unsigned WIDTH     = 36
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 full_reset_n_i,
  input  wire logic                 retransmit_n_i,
  input  wire logic                 retransmit_mode_select_i,
  input  wire logic                 byte_order_timing_select_i,
  input  wire logic                 flag_select_msb_i,
  input  wire logic                 flag_select_mid_serial_load_n_i,
  input  wire logic                 flag_select_lsb_serial_data_i,
  input  wire fcp_pkg::fcp_port_ctl_t port_a_ctl_i,
  input  wire logic [WIDTH-1:0]     port_a_data_i,
  output logic [WIDTH-1:0]          port_a_data_o,
  output logic                      port_a_data_oe_o,
  input  wire fcp_pkg::fcp_port_ctl_t port_b_ctl_i,
  output logic [WIDTH-1:0]          port_b_data_o,
  output logic                      port_b_data_oe_o,
  output logic                      full_input_ready_flag_o,
  output logic                      empty_output_ready_flag_o,
  output logic                      almost_empty_flag_o,
  output logic                      almost_full_flag_o,
  output logic                      big_endian_o,
  output logic                      fall_through_mode_o,
  output logic                      interspersed_parity_mode_o,
  output logic [12:0]               almost_empty_offset_o,
  output logic [12:0]               almost_full_offset_o,
  output logic [WIDTH-1:0]          mailbox1_o
);
  localparam int unsigned DEPTH = 1 << DEPTH_LOG;
  localparam int unsigned OW    = DEPTH_LOG;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                 rst_q;
    logic                 mode_pend;
    logic                 fall_through;
    logic                 big_endian;
    fcp_pkg::fcp_prog_t   prog;
    logic [1:0]           par_cnt;
    logic [5:0]           ser_cnt;
    logic [12:0]          ae_ofs;
    logic [12:0]          af_ofs;
    logic [1:0]           rdy_cnt;
    logic                 cfg_done;
    logic [DEPTH_LOG:0]   wptr;
    logic [DEPTH_LOG:0]   rptr;
    logic                 out_valid;
    logic [WIDTH-1:0]     out_word;
    logic [WIDTH-1:0]     mail1;
  } fcp_state_t;

  fcp_state_t st_r;
  fcp_state_t st_nxt;
  logic [WIDTH-1:0] mem_r [DEPTH];

  logic full_held;
  logic shared_held;
  logic [DEPTH_LOG:0] words;
  logic fifo_full;
  logic fifo_empty;
  logic wr_ok;
  logic rd_req;
  logic rd_ok;
  logic [12:0] par_val;
  logic [12:0] preset;
  logic partial_rst;
  logic retransmit;

  // ----------------------------------------------------------------
  // reset pin qualification
  // ----------------------------------------------------------------
  fcp_low_counter #(.NEED(fcp_pkg::RST_EDGES)) u_full_cnt (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_n_i (full_reset_n_i),
    .held_o  (full_held)
  );

  fcp_low_counter #(.NEED(fcp_pkg::RST_EDGES)) u_shared_cnt (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_n_i (retransmit_n_i),
    .held_o  (shared_held)
  );

  // shared pin meaning follows mode select while held
  assign partial_rst = shared_held && !retransmit_mode_select_i;
  assign retransmit  = shared_held && retransmit_mode_select_i;

  // ----------------------------------------------------------------
  // fifo status
  // ----------------------------------------------------------------
  assign words      = st_r.wptr - st_r.rptr;
  assign fifo_full  = words == (DEPTH_LOG+1)'(DEPTH);
  assign fifo_empty = words == '0;

  // write qualifier, independent of port b
  assign wr_ok = !port_a_ctl_i.port_a_select_n &&
                 port_a_ctl_i.port_a_direction &&
                 port_a_ctl_i.port_a_transfer_qualifier &&
                 full_input_ready_flag_o;
  // read qualifier
  assign rd_req = !port_b_ctl_i.port_a_select_n &&
                  port_b_ctl_i.port_a_direction &&
                  port_b_ctl_i.port_a_transfer_qualifier &&
                  !port_b_ctl_i.port_a_mailbox_select;
  assign rd_ok = rd_req && empty_output_ready_flag_o;

  // offset from port a bits; interspersed layout drops bit 8
  always_comb begin
    par_val = '0;
    if (st_r.prog == fcp_pkg::FCP_PROG_IP) begin
      par_val = 13'({port_a_data_i[OW:fcp_pkg::PARITY_BIT+1],
                     port_a_data_i[fcp_pkg::PARITY_BIT-1:0]});
    end else begin
      par_val = 13'(port_a_data_i[OW-1:0]);
    end
  end

  // preset decode from msb, mid, lsb
  always_comb begin
    unique case ({flag_select_msb_i, flag_select_mid_serial_load_n_i,
                  flag_select_lsb_serial_data_i})
      3'h7:    preset = fcp_pkg::OFS_64;
      3'h6:    preset = fcp_pkg::OFS_16;
      3'h5:    preset = fcp_pkg::OFS_8;
      3'h3:    preset = fcp_pkg::OFS_256;
      3'h1:    preset = fcp_pkg::OFS_1024;
      default: preset = fcp_pkg::OFS_RST;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.rst_q = full_held;

    // release edge of full reset latches configuration
    if (st_r.rst_q && !full_held) begin
      st_nxt.big_endian = byte_order_timing_select_i;
      st_nxt.mode_pend  = 1'b1;
      st_nxt.par_cnt    = 2'h0;
      st_nxt.ser_cnt    = 6'h0;
      st_nxt.cfg_done   = 1'b0;
      st_nxt.ae_ofs     = preset;
      st_nxt.af_ofs     = preset;
      if (!flag_select_mid_serial_load_n_i &&
          !flag_select_lsb_serial_data_i) begin
        st_nxt.prog = flag_select_msb_i ? fcp_pkg::FCP_PROG_PAR
                                        : fcp_pkg::FCP_PROG_IP;
      end else if (!flag_select_msb_i &&
                   flag_select_mid_serial_load_n_i &&
                   !flag_select_lsb_serial_data_i) begin
        st_nxt.prog = fcp_pkg::FCP_PROG_SERIAL;
      end else begin
        st_nxt.prog     = fcp_pkg::FCP_PROG_PRESET;
        st_nxt.cfg_done = 1'b1;
      end
    end else if (st_r.mode_pend) begin
      // first edge after release picks timing mode
      st_nxt.fall_through = !byte_order_timing_select_i;
      st_nxt.mode_pend    = 1'b0;
    end

    // ready delay after any reset
    if (!st_r.rdy_cnt[1] && !full_held && !partial_rst) begin
      st_nxt.rdy_cnt = st_r.rdy_cnt + 2'h1;
    end

    // serial shift, full offset first; interspersed_parity_mode never enters here
    if (st_r.prog == fcp_pkg::FCP_PROG_SERIAL && !st_r.cfg_done &&
        !full_held && !flag_select_mid_serial_load_n_i) begin
      if (st_r.ser_cnt < 6'(OW)) begin
        st_nxt.af_ofs = 13'({st_r.af_ofs[OW-2:0],
                             flag_select_lsb_serial_data_i});
      end else begin
        st_nxt.ae_ofs = 13'({st_r.ae_ofs[OW-2:0],
                             flag_select_lsb_serial_data_i});
      end
      st_nxt.ser_cnt = st_r.ser_cnt + 6'h1;
      if (st_r.ser_cnt == 6'(2*OW-1)) begin
        st_nxt.cfg_done = 1'b1;
      end
    end

    // port a writes: offsets, mailbox, or fifo memory
    if (wr_ok && port_a_ctl_i.port_a_mailbox_select) begin
      st_nxt.mail1 = port_a_data_i;
    end else if (wr_ok && !st_r.cfg_done) begin
      if (st_r.par_cnt == 2'h0) begin
        st_nxt.af_ofs = par_val;
      end else begin
        st_nxt.ae_ofs   = par_val;
        st_nxt.cfg_done = 1'b1;
      end
      st_nxt.par_cnt = st_r.par_cnt + 2'h1;
    end else if (wr_ok) begin
      st_nxt.wptr = st_r.wptr + 1'b1;
    end

    // output register loading
    if (st_r.fall_through) begin
      if ((!st_r.out_valid || rd_req) && !fifo_empty) begin
        st_nxt.out_word  = mem_r[st_r.rptr[DEPTH_LOG-1:0]];
        st_nxt.out_valid = 1'b1;
        st_nxt.rptr      = st_r.rptr + 1'b1;
      end else if (rd_req && st_r.out_valid) begin
        st_nxt.out_valid = 1'b0;
      end
    end else if (rd_ok) begin
      st_nxt.out_word = mem_r[st_r.rptr[DEPTH_LOG-1:0]];
      st_nxt.rptr     = st_r.rptr + 1'b1;
    end

    if (retransmit) begin
      st_nxt.rptr      = '0;
      st_nxt.out_valid = 1'b0;
    end
    // partial reset clears pointers and flags, and ends offset loading in parallel modes
    if (partial_rst || full_held) begin
      st_nxt.wptr      = '0;
      st_nxt.rptr      = '0;
      st_nxt.out_valid = 1'b0;
      st_nxt.rdy_cnt   = 2'h0;
      st_nxt.mail1     = st_r.mail1;
    end
    if (partial_rst && (st_r.prog == fcp_pkg::FCP_PROG_PAR ||
                        st_r.prog == fcp_pkg::FCP_PROG_IP)) begin
      st_nxt.cfg_done = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '{rst_q: 1'b0, mode_pend: 1'b0, fall_through: 1'b0,
                big_endian: 1'b0, prog: fcp_pkg::FCP_PROG_PRESET,
                par_cnt: 2'h0, ser_cnt: 6'h0,
                ae_ofs: fcp_pkg::OFS_RST, af_ofs: fcp_pkg::OFS_RST,
                rdy_cnt: 2'h0, cfg_done: 1'b1, wptr: '0, rptr: '0,
                out_valid: 1'b0, out_word: '0, mail1: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // memory has no reset; contents are undefined until written
  always_ff @(posedge clk_i) begin
    if (wr_ok && st_r.cfg_done && !port_a_ctl_i.port_a_mailbox_select &&
        !partial_rst && !full_held) begin
      mem_r[st_r.wptr[DEPTH_LOG-1:0]] <= port_a_data_i;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // parallel loading needs the flag high so the two offset writes qualify;
  // only the serial load keeps it low until the last bit is in
  assign full_input_ready_flag_o = st_r.rdy_cnt[1] && !fifo_full &&
                                   !(st_r.prog == fcp_pkg::FCP_PROG_SERIAL &&
                                     !st_r.cfg_done);
  assign empty_output_ready_flag_o = st_r.fall_through ? st_r.out_valid
                                                       : !fifo_empty;
  assign almost_empty_flag_o = words > (DEPTH_LOG+1)'(st_r.ae_ofs);
  assign almost_full_flag_o  = words < (DEPTH_LOG+1)'(DEPTH) -
                               (DEPTH_LOG+1)'(st_r.af_ofs);
  assign port_a_data_oe_o = !port_a_ctl_i.port_a_select_n &&
                            !port_a_ctl_i.port_a_direction;
  assign port_b_data_oe_o = !port_b_ctl_i.port_a_select_n &&
                            port_b_ctl_i.port_a_direction;
  assign port_a_data_o = '0;
  assign port_b_data_o = st_r.out_word;
  assign big_endian_o = st_r.big_endian;
  assign fall_through_mode_o = st_r.fall_through;
  assign interspersed_parity_mode_o = st_r.prog == fcp_pkg::FCP_PROG_IP;
  assign almost_empty_offset_o = st_r.ae_ofs;
  assign almost_full_offset_o  = st_r.af_ofs;
  assign mailbox1_o = st_r.mail1;
endmodule

// ==== dv/fcp_fifo_ctrl_asserts.sv ====
// checker: port-level properties of the fifo control block
`timescale 1ns/1ps
module fcp_fifo_ctrl_asserts #(
  parameter int unsigned WIDTH = 36
) (
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire logic                   full_reset_n_i,
  input wire logic                   retransmit_n_i,
  input wire logic                   retransmit_mode_select_i,
  input wire fcp_pkg::fcp_port_ctl_t port_a_ctl_i,
  input wire logic [WIDTH-1:0]       port_a_data_i,
  input wire logic                   port_a_data_oe_o,
  input wire fcp_pkg::fcp_port_ctl_t port_b_ctl_i,
  input wire logic                   port_b_data_oe_o,
  input wire logic                   full_input_ready_flag_o,
  input wire logic                   empty_output_ready_flag_o,
  input wire logic                   fall_through_mode_o,
  input wire logic                   big_endian_o,
  input wire logic [12:0]            almost_full_offset_o,
  input wire logic [WIDTH-1:0]       mailbox1_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  sequence s_part_held;
    (!retransmit_n_i && !retransmit_mode_select_i && full_reset_n_i) [*6];
  endsequence
  sequence s_mb_write;
    !port_a_ctl_i.port_a_select_n && port_a_ctl_i.port_a_direction &&
    port_a_ctl_i.port_a_transfer_qualifier &&
    port_a_ctl_i.port_a_mailbox_select && full_input_ready_flag_o;
  endsequence
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_porta_drive: assert property (
    port_a_data_oe_o == (!port_a_ctl_i.port_a_select_n &&
    !port_a_ctl_i.port_a_direction)) else $error("port a drive wrong");
  a_portb_drive: assert property (
    port_b_data_oe_o == (!port_b_ctl_i.port_a_select_n &&
    port_b_ctl_i.port_a_direction)) else $error("port b drive wrong");
  a_ready_after_rst: assert property (
    $fell(rst_i) && full_reset_n_i |-> ##[1:4] full_input_ready_flag_o)
    else $error("ready flag late after reset");
  a_ready_in_rst: assert property (
    (!full_reset_n_i) [*6] |-> !full_input_ready_flag_o)
    else $error("ready flag high in reset");
  a_part_flags: assert property (
    s_part_held |-> !full_input_ready_flag_o && !empty_output_ready_flag_o)
    else $error("flags high in partial reset");
  a_part_ready: assert property (
    s_part_held ##1 retransmit_n_i |-> ##[1:6] full_input_ready_flag_o)
    else $error("ready flag late after partial reset");
  a_part_keeps: assert property (
    s_part_held |=> ($stable(almost_full_offset_o) &&
    $stable(fall_through_mode_o)) [*4]) else $error("setting lost");
  a_config_hold: assert property (
    full_reset_n_i [*6] |-> $stable(big_endian_o) &&
    $stable(fall_through_mode_o)) else $error("config moved");
  a_mbox_store: assert property (
    s_mb_write |=> mailbox1_o == $past(port_a_data_i))
    else $error("mailbox word wrong");
endmodule

bind fcp_fifo_ctrl fcp_fifo_ctrl_asserts #(.WIDTH(WIDTH)) u_asserts (
  .clk_i(clk_i), .rst_i(rst_i), .full_reset_n_i(full_reset_n_i),
  .retransmit_n_i(retransmit_n_i),
  .retransmit_mode_select_i(retransmit_mode_select_i),
  .port_a_ctl_i(port_a_ctl_i), .port_a_data_i(port_a_data_i),
  .port_a_data_oe_o(port_a_data_oe_o), .port_b_ctl_i(port_b_ctl_i),
  .port_b_data_oe_o(port_b_data_oe_o),
  .full_input_ready_flag_o(full_input_ready_flag_o),
  .empty_output_ready_flag_o(empty_output_ready_flag_o),
  .fall_through_mode_o(fall_through_mode_o), .big_endian_o(big_endian_o),
  .almost_full_offset_o(almost_full_offset_o), .mailbox1_o(mailbox1_o));

// ==== dv/fcp_host_model.sv ====
// model: host controllers on port a (writer) and port b (reader)
`timescale 1ns/1ps
module fcp_host_model (
  input  wire logic              clk_i,
  input  wire logic              ready_i,
  output fcp_pkg::fcp_port_ctl_t a_ctl_o,
  output logic [35:0]            a_data_o,
  output fcp_pkg::fcp_port_ctl_t b_ctl_o
);
  initial begin
    a_ctl_o = '{1'b1, 1'b1, 1'b0, 1'b0};
    b_ctl_o = '{1'b1, 1'b1, 1'b0, 1'b0};
    a_data_o = 36'h0;
  end
  // strobe stays up on return so calls can run back to back
  task write(input logic mb, input logic [35:0] d);
    @(negedge clk_i);
    for (int i = 0; i < 40 && ready_i !== 1'b1; i++) @(negedge clk_i);
    a_ctl_o = '{1'b0, 1'b1, 1'b1, mb};
    a_data_o = d;
    @(posedge clk_i);
  endtask
  task read();
    @(negedge clk_i);
    b_ctl_o = '{1'b0, 1'b1, 1'b1, 1'b0};
    @(negedge clk_i);
    b_ctl_o.port_a_transfer_qualifier = 1'b0;
  endtask
  task idle(input logic sel_n, input logic dir);
    @(negedge clk_i);
    a_ctl_o = '{sel_n, dir, 1'b0, 1'b0};
    b_ctl_o = '{sel_n, dir, 1'b0, 1'b0};
    a_data_o = ~a_data_o; // released lines must not keep the old word
  endtask
endmodule

// ==== dv/tb_fifo_config_and_port_control.sv ====
// testbench: self-checking run of the fifo control block
`timescale 1ns/1ps
module tb_fifo_config_and_port_control;
  logic                   clk_i = 1'b0;
  logic                   rst, fr_n, rt_n, retransmit_mode_select, bo, fs2, fs1, fs0;
  logic                   oea, oeb, ff, ef, be, ft, ipm;
  fcp_pkg::fcp_port_ctl_t pa_ctl, pb_ctl;
  logic [35:0]            pa_d, pb, mb1, w [3];
  logic [12:0]            aeo, afo, v;
  logic [31:0]            r, seed = 32'h248E;
  logic [21:0]            bits;
  logic [2:0]             codes [5] = '{3'h7, 3'h6, 3'h5, 3'h3, 3'h1};
  int                     n_errors = 0;
  int                     checks = 0;

  always #2.5 clk_i = ~clk_i;

  fcp_fifo_ctrl u_dut (
    .clk_i(clk_i), .rst_i(rst), .full_reset_n_i(fr_n),
    .retransmit_n_i(rt_n), .retransmit_mode_select_i(retransmit_mode_select),
    .byte_order_timing_select_i(bo), .flag_select_msb_i(fs2),
    .flag_select_mid_serial_load_n_i(fs1),
    .flag_select_lsb_serial_data_i(fs0), .port_a_ctl_i(pa_ctl),
    .port_a_data_i(pa_d), .port_a_data_o(), .port_a_data_oe_o(oea),
    .port_b_ctl_i(pb_ctl), .port_b_data_o(pb), .port_b_data_oe_o(oeb),
    .full_input_ready_flag_o(ff), .empty_output_ready_flag_o(ef),
    .almost_empty_flag_o(), .almost_full_flag_o(), .big_endian_o(be),
    .fall_through_mode_o(ft), .interspersed_parity_mode_o(ipm),
    .almost_empty_offset_o(aeo), .almost_full_offset_o(afo),
    .mailbox1_o(mb1));
  fcp_host_model u_host (.clk_i(clk_i), .ready_i(ff), .a_ctl_o(pa_ctl),
    .a_data_o(pa_d), .b_ctl_o(pb_ctl));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic [12:0] preset(input logic [2:0] c);
    case (c)
      3'h7: return fcp_pkg::OFS_64;
      3'h6: return fcp_pkg::OFS_16;
      3'h5: return fcp_pkg::OFS_8;
      3'h3: return fcp_pkg::OFS_256;
      default: return fcp_pkg::OFS_1024;
    endcase
  endfunction
  function logic [12:0] par_ofs(input logic [35:0] d, input logic ip);
    return ip ? {2'h0, d[11:9], d[7:0]} : {2'h0, d[10:0]};
  endfunction
  task chk(input logic [35:0] got, input logic [35:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wait_ff();
    for (int i = 0; i < 40 && ff !== 1'b1; i++) @(negedge clk_i);
  endtask
  task wait_ef();
    for (int i = 0; i < 40 && ef !== 1'b1; i++) @(negedge clk_i);
  endtask
  // byte order sampled at release, timing level from two clocks on
  task freset(input logic [2:0] c, input logic b, input logic m);
    @(negedge clk_i);
    fr_n = 1'b0;
    {fs2, fs1, fs0} = c;
    bo = b;
    repeat (6) @(negedge clk_i);
    fr_n = 1'b1;
    repeat (2) @(negedge clk_i);
    bo = m;
  endtask
  task shared_pin(input logic mode);
    @(negedge clk_i);
    retransmit_mode_select = mode;
    @(negedge clk_i);
    rt_n = 1'b0;
    repeat (6) @(negedge clk_i);
    if (!mode) chk(ef, 1'b0);
    rt_n = 1'b1;
  endtask
  task print_verdict();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    #100000;
    n_errors++;
    print_verdict();
  end
  initial begin
    rst = 1'b1;
    fr_n = 1'b1;
    rt_n = 1'b1;
    retransmit_mode_select = 1'b1;
    bo = 1'b1;
    {fs2, fs1, fs0} = 3'h7;
    repeat (8) @(negedge clk_i);
    rst = 1'b0;
    wait_ff();
    chk(ff, 1'b1);
    for (int i = 0; i < 4; i++) begin
      u_host.idle(i[1], i[0]);
      #1;
      chk(oea, i == 0);
      chk(oeb, i == 1);
    end
    foreach (codes[k]) begin
      r = rnd();
      freset(codes[k], r[0], r[1]);
      wait_ff();
      chk(afo, preset(codes[k]));
      chk(aeo, preset(codes[k]));
      chk(be, r[0]);
      chk(ft, !r[1]);
    end
    freset(3'h7, 1'b0, 1'b1);
    wait_ff();
    foreach (w[k]) begin
      w[k] = 36'({rnd(), rnd()});
      u_host.write(1'b0, w[k]);
    end
    u_host.idle(1'b0, 1'b1);
    chk(pb === w[0], 1'b0);
    wait_ef();
    u_host.read();
    chk(pb, w[0]);
    r = rnd();
    u_host.write(1'b1, 36'(r));
    u_host.idle(1'b0, 1'b1);
    chk(mb1, 36'(r));
    shared_pin(1'b1);
    wait_ef();
    u_host.read();
    chk(pb, w[0]);
    shared_pin(1'b0);
    wait_ff();
    chk(ff, 1'b1);
    chk(ft, 1'b0);
    chk(afo, fcp_pkg::OFS_64);
    freset(3'h7, 1'b0, 1'b0);
    wait_ff();
    u_host.write(1'b0, w[1]);
    u_host.write(1'b0, w[2]);
    u_host.idle(1'b0, 1'b1);
    wait_ef();
    chk(pb, w[1]);
    repeat (3) @(negedge clk_i);
    chk(pb, w[1]);
    u_host.read();
    chk(pb, w[2]);
    for (int ip = 0; ip < 2; ip++) begin
      freset(ip ? 3'h0 : 3'h4, 1'b0, 1'b1);
      wait_ff();
      foreach (w[k]) begin
        r = rnd();
        v = 13'(1 + r % 2044);
        w[k] = 36'({rnd(), rnd()});
        if (ip) {w[k][11:9], w[k][7:0]} = v[10:0];
        else w[k][10:0] = v[10:0];
        u_host.write(1'b0, w[k]);
      end
      u_host.idle(1'b0, 1'b1);
      chk(afo, par_ofs(w[0], ip[0]));
      chk(aeo, par_ofs(w[1], ip[0]));
      chk(ipm, ip[0]);
      wait_ef();
      u_host.read();
      chk(pb, w[2]);
    end
    freset(3'h2, 1'b0, 1'b1);
    r = rnd();
    bits = {11'(1 + r[15:0] % 2044), 11'(1 + r[31:16] % 2044)};
    for (int i = 21; i >= 0; i--) begin
      chk(ff, 1'b0);
      fs1 = 1'b0;
      fs0 = bits[i];
      @(negedge clk_i);
    end
    fs1 = 1'b1;
    @(negedge clk_i);
    chk(ff, 1'b1);
    chk(afo, {2'h0, bits[21:11]});
    chk(aeo, {2'h0, bits[10:0]});
    print_verdict();
  end
endmodule
